// ==== hw/mps_pkg.sv ====
// What this block does
// - Power-good high permits sequencing; low holds the module in reset.
// - Active-low supply-on output switches on the ATX supply main outputs.
// - Power-button press requests power on or off, per firmware policy.
// - After AC loss, restore per policy: always on, remain off, last state; reset loads the last state as off (MPS_RST_LAST_ON).
// - Multi-stage watchdog kicked only by software, no hardware trigger.
// - Drive a PWM fan control output.
// - Fan tachometer counted at two pulses per revolution.
`default_nettype none
package mps_pkg;

   typedef enum logic [1:0]
   {
      MPS_POL_ALWAYS_ON,
      MPS_POL_REMAIN_OFF,
      MPS_POL_LAST_STATE
   } mps_policy_t;

   typedef enum logic [2:0]
   {
      MPS_ST_AC_UP,
      MPS_ST_OFF,
      MPS_ST_WAIT_PG,
      MPS_ST_RUN
   } mps_state_t;

   typedef enum logic [1:0]
   {
      MPS_WD_NONE,
      MPS_WD_IRQ,
      MPS_WD_RESET,
      MPS_WD_POWER_OFF
   } mps_wd_action_t;

   // Software controls, sampled each cycle
   typedef struct packed
   {
      mps_policy_t    policy;
      logic           btn_toggles;
      logic           wd_enable;
      logic           wd_kick;
      logic [31:0]    wd_stage1;
      logic [31:0]    wd_stage2;
      logic [7:0]     fan_duty;
   } mps_ctrl_t;

   // Status shown to software
   typedef struct packed
   {
      logic           powered;
      logic           in_reset;
      logic [1:0]     wd_stage;
      logic           wd_event;
      logic [15:0]    fan_revs;
   } mps_stat_t;

   localparam int unsigned MPS_CLK_HZ        = 125_000_000;
   localparam int unsigned MPS_TACH_WIN_MS   = 1000;
   localparam int unsigned MPS_TACH_WIN_CYC  =
      MPS_CLK_HZ / 1000 * MPS_TACH_WIN_MS;
   localparam int unsigned MPS_TACH_PPR      = 2;
   localparam int unsigned MPS_PWM_STEPS     = 256;
   localparam logic        MPS_RST_LAST_ON   = 1'b0;

endpackage : mps_pkg
`default_nettype wire

// ==== hw/mps_fan.sv ====
`timescale 1ns/1ps
`default_nettype none
// PWM drive and tachometer count; fan_revs updates once per window
module mps_fan
   import mps_pkg::*;
#(
   parameter int unsigned WIN_CYC = MPS_TACH_WIN_CYC
)
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Control
   input  wire logic [7:0]  duty,
   input  wire logic        tach_in,
   // Outputs
   output logic             pwm_out,
   output logic [15:0]      revs
);

   typedef struct packed
   {
      logic [7:0]  pwm_cnt;
      logic        pwm;
      logic        tach_d;
      logic [31:0] win;
      logic [16:0] pulses;
      logic [15:0] revs;
   } mps_fan_st_t;

   mps_fan_st_t st_r;
   mps_fan_st_t st_nxt;

   always_comb
   begin
      st_nxt         = st_r;
      st_nxt.pwm_cnt = st_r.pwm_cnt + 8'h01;
      st_nxt.pwm     = (st_r.pwm_cnt < duty) || (duty == 8'hff);
      st_nxt.tach_d  = tach_in;
      if (tach_in && !st_r.tach_d)
      begin
         st_nxt.pulses = st_r.pulses + 17'h00001;
      end
      if (st_r.win >= WIN_CYC - 1)
      begin
         st_nxt.win    = 32'h0;
         // Two pulses make one revolution
         st_nxt.revs   = st_r.pulses[16:1];
         st_nxt.pulses = 17'h0;
      end
      else
      begin
         st_nxt.win = st_r.win + 32'h1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign pwm_out = st_r.pwm;
   assign revs    = st_r.revs;

   property p_pwm_full;
      @(posedge sys_clk) disable iff (!rst_n)
      (duty == 8'hff) ##1 (duty == 8'hff) |-> pwm_out;
   endproperty
   a_pwm_full : assert property (p_pwm_full)
      else $error("pwm not high at full duty");

   property p_pwm_zero;
      @(posedge sys_clk) disable iff (!rst_n)
      (duty == 8'h00) ##1 (duty == 8'h00) |-> !pwm_out;
   endproperty
   a_pwm_zero : assert property (p_pwm_zero)
      else $error("pwm high at zero duty");

   property p_revs_half;
      @(posedge sys_clk) disable iff (!rst_n)
      (st_r.win >= WIN_CYC - 1) |=> (revs == $past(st_r.pulses[16:1]));
   endproperty
   a_revs_half : assert property (p_revs_half)
      else $error("revolutions not half of pulse count");

endmodule : mps_fan
`default_nettype wire

// ==== hw/mps_seq.sv ====
`timescale 1ns/1ps
`default_nettype none
module mps_seq
   import mps_pkg::*;
#(
   parameter int unsigned TACH_WIN_CYC = MPS_TACH_WIN_CYC
)
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Carrier pins
   input  wire logic        power_good_in,
   input  wire logic        power_button_n,
   input  wire logic        fan_speed_pulse_in,
   output logic             supply_on_n,
   output logic             fan_drive_out,
   // Module side
   output logic             module_reset_n,
   output logic             wd_irq,
   // Software
   input  wire mps_ctrl_t   ctrl,
   output mps_stat_t        stat
);

   typedef struct packed
   {
      mps_state_t  state;
      logic        last_on;
      logic        btn_d;
      logic [1:0]  wd_stage;
      logic [31:0] wd_cnt;
      logic        wd_event;
      logic        supply_on_n;
      logic        mod_rst_n;
      logic        in_reset;
      logic        wd_irq;
   } mps_seq_st_t;

   mps_seq_st_t st_r;
   mps_seq_st_t st_nxt;
   logic        btn_press;
   logic [15:0] fan_revs;

   // Button is debounced outside, so an edge is a single press
   assign btn_press = st_r.btn_d && !power_button_n;

   always_comb
   begin
      st_nxt          = st_r;
      st_nxt.btn_d    = power_button_n;
      st_nxt.wd_event = 1'b0;
      st_nxt.wd_irq   = 1'b0;
      unique case (st_r.state)
         MPS_ST_AC_UP:
         begin
            if (ctrl.policy == MPS_POL_ALWAYS_ON ||
                (ctrl.policy == MPS_POL_LAST_STATE && st_r.last_on))
               st_nxt.state = MPS_ST_WAIT_PG;
            else
               st_nxt.state = MPS_ST_OFF;
         end
         MPS_ST_OFF:
         begin
            if (btn_press)
               st_nxt.state = MPS_ST_WAIT_PG;
         end
         MPS_ST_WAIT_PG:
         begin
            if (power_good_in)
               st_nxt.state = MPS_ST_RUN;
            else if (btn_press && ctrl.btn_toggles)
               st_nxt.state = MPS_ST_OFF;
         end
         MPS_ST_RUN:
         begin
            if (!power_good_in)
               st_nxt.state = MPS_ST_WAIT_PG;
            else if (btn_press && ctrl.btn_toggles)
               st_nxt.state = MPS_ST_OFF;
         end
         default:
            st_nxt.state = MPS_ST_OFF;
      endcase

      // Software-only watchdog; no pin can kick it
      if (st_r.state != MPS_ST_RUN || !ctrl.wd_enable || ctrl.wd_kick)
      begin
         st_nxt.wd_stage = 2'h0;
         st_nxt.wd_cnt   = 32'h0;
      end
      else if (st_r.wd_stage == 2'h0 && st_r.wd_cnt >= ctrl.wd_stage1)
      begin
         st_nxt.wd_stage = 2'h1;
         st_nxt.wd_cnt   = 32'h0;
         st_nxt.wd_irq   = 1'b1;
         st_nxt.wd_event = 1'b1;
      end
      else if (st_r.wd_stage == 2'h1 && st_r.wd_cnt >= ctrl.wd_stage2)
      begin
         // Second stage switches the supply off through the off state; only a button press powers up again
         st_nxt.wd_stage = 2'h2;
         st_nxt.wd_event = 1'b1;
         st_nxt.state    = MPS_ST_OFF;
      end
      else
      begin
         st_nxt.wd_cnt = st_r.wd_cnt + 32'h1;
      end

      st_nxt.last_on = (st_nxt.state == MPS_ST_WAIT_PG) ||
                       (st_nxt.state == MPS_ST_RUN);
      st_nxt.supply_on_n = !st_nxt.last_on;
      st_nxt.mod_rst_n   = (st_nxt.state == MPS_ST_RUN) &&
                           power_good_in;
      // Status copy kept in its own flop so the port needs no inverter
      st_nxt.in_reset    = !st_nxt.mod_rst_n;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         st_r             <= '0;
         st_r.state       <= MPS_ST_AC_UP;
         st_r.last_on     <= MPS_RST_LAST_ON;
         st_r.btn_d       <= 1'b1;
         st_r.supply_on_n <= 1'b1;
         st_r.in_reset    <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   mps_fan #(
      .WIN_CYC (TACH_WIN_CYC)
   ) mps_fan_i (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .duty    (ctrl.fan_duty),
      .tach_in (fan_speed_pulse_in),
      .pwm_out (fan_drive_out),
      .revs    (fan_revs)
   );

   assign supply_on_n    = st_r.supply_on_n;
   assign module_reset_n = st_r.mod_rst_n;
   assign wd_irq         = st_r.wd_irq;
   assign stat.powered   = st_r.last_on;
   assign stat.in_reset  = st_r.in_reset;
   assign stat.wd_stage  = st_r.wd_stage;
   assign stat.wd_event  = st_r.wd_event;
   assign stat.fan_revs  = fan_revs;

   property p_reset_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      !power_good_in |=> !module_reset_n;
   endproperty
   a_reset_hold : assert property (p_reset_hold)
      else $error("module left reset while power-good low");

   property p_supply_match;
      @(posedge sys_clk) disable iff (!rst_n)
      (st_r.state == MPS_ST_RUN) |-> !supply_on_n;
   endproperty
   a_supply_match : assert property (p_supply_match)
      else $error("running with supply off");

   sequence s_off_press;
      (st_r.state == MPS_ST_OFF) && btn_press;
   endsequence
   property p_press_on;
      @(posedge sys_clk) disable iff (!rst_n)
      s_off_press ##0 (st_r.wd_stage != 2'h2) |=> !supply_on_n;
   endproperty
   a_press_on : assert property (p_press_on)
      else $error("button press did not switch supply on");

   property p_wait_pg;
      @(posedge sys_clk) disable iff (!rst_n)
      (st_r.state == MPS_ST_WAIT_PG) && !power_good_in |=>
         !module_reset_n;
   endproperty
   a_wait_pg : assert property (p_wait_pg)
      else $error("reset released before power-good");

   property p_policy_off;
      @(posedge sys_clk) disable iff (!rst_n)
      (st_r.state == MPS_ST_AC_UP) && ctrl.policy == MPS_POL_REMAIN_OFF
         |=> st_r.state == MPS_ST_OFF;
   endproperty
   a_policy_off : assert property (p_policy_off)
      else $error("remain-off policy powered up");

   property p_wd_kick;
      @(posedge sys_clk) disable iff (!rst_n)
      ctrl.wd_kick |=> st_r.wd_stage == 2'h0 && !wd_irq;
   endproperty
   a_wd_kick : assert property (p_wd_kick)
      else $error("watchdog advanced after kick");

   property p_irq_pulse;
      @(posedge sys_clk) disable iff (!rst_n)
      wd_irq |=> !wd_irq;
   endproperty
   a_irq_pulse : assert property (p_irq_pulse)
      else $error("watchdog interrupt longer than one cycle");

   sequence s_run_toggle;
      (st_r.state == MPS_ST_RUN) && power_good_in && btn_press &&
         ctrl.btn_toggles;
   endsequence
   property p_press_off;
      @(posedge sys_clk) disable iff (!rst_n)
      s_run_toggle |=> supply_on_n && !module_reset_n;
   endproperty
   a_press_off : assert property (p_press_off)
      else $error("toggle press did not switch supply off");

   sequence s_pg_seen;
      (st_r.state == MPS_ST_WAIT_PG) && power_good_in;
   endsequence
   property p_pg_release;
      @(posedge sys_clk) disable iff (!rst_n)
      s_pg_seen |=> module_reset_n && !supply_on_n;
   endproperty
   a_pg_release : assert property (p_pg_release)
      else $error("reset not released after power-good");

endmodule : mps_seq
`default_nettype wire

// ==== test/mps_carrier.sv ====
`timescale 1ns/1ps
`default_nettype none
// Carrier side: supply, regulators, power button and fan
module mps_carrier
#(
   parameter int unsigned PG_DLY = 10
)
(
   // Clock
   input  wire logic sys_clk,
   // Bench requests
   input  wire logic press,
   input  wire logic pg_kill,
   input  wire logic tach_on,
   // Carrier pins
   input  wire logic supply_on_n,
   output logic      power_good_in,
   output logic      power_button_n,
   output logic      fan_speed_pulse_in
);
   int unsigned up_cnt  = 0;
   int unsigned btn_cnt = 0;
   logic [2:0]  tach_cnt = 3'h0;

   initial power_good_in = 1'b0;
   initial power_button_n = 1'b1;
   initial fan_speed_pulse_in = 1'b0;

   // Power good only after rails settle plus a margin
   always @(posedge sys_clk)
   begin
      if (supply_on_n || pg_kill)
         up_cnt <= 0;
      else if (up_cnt < PG_DLY)
         up_cnt <= up_cnt + 1;
      power_good_in <= !supply_on_n && !pg_kill && up_cnt == PG_DLY;
   end

   // Clean momentary press; the pull-up returns the pin high
   always @(posedge sys_clk)
   begin
      if (press)
         btn_cnt <= 4;
      else if (btn_cnt != 0)
         btn_cnt <= btn_cnt - 1;
      power_button_n <= !(press || btn_cnt > 1);
   end

   // Two pulses per 16-cycle revolution
   always @(posedge sys_clk)
   begin
      tach_cnt <= tach_on ? tach_cnt + 3'h1 : 3'h0;
      fan_speed_pulse_in <= tach_cnt[2];
   end
endmodule : mps_carrier
`default_nettype wire

// ==== test/mps_seq_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module mps_seq_bench;
   import mps_pkg::*;
   logic      sys_clk = 1'b0;
   logic      rst_n, press, pg_kill, tach_on;
   logic      power_good_in, power_button_n, fan_speed_pulse_in;
   logic      supply_on_n, fan_drive_out, module_reset_n, wd_irq;
   mps_ctrl_t ctrl;
   mps_stat_t stat;
   int        n_mismatch = 0;
   int        num_checks = 0;

   initial forever #4 sys_clk = ~sys_clk;

   mps_seq #(.TACH_WIN_CYC(100)) mps_seq_i
   (
      .sys_clk(sys_clk), .rst_n(rst_n), .power_good_in(power_good_in),
      .power_button_n(power_button_n),
      .fan_speed_pulse_in(fan_speed_pulse_in), .supply_on_n(supply_on_n),
      .fan_drive_out(fan_drive_out), .module_reset_n(module_reset_n),
      .wd_irq(wd_irq), .ctrl(ctrl), .stat(stat)
   );

   mps_carrier #(.PG_DLY(10)) mps_carrier_i
   (
      .sys_clk(sys_clk), .press(press), .pg_kill(pg_kill),
      .tach_on(tach_on), .supply_on_n(supply_on_n),
      .power_good_in(power_good_in), .power_button_n(power_button_n),
      .fan_speed_pulse_in(fan_speed_pulse_in)
   );

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [15:0] exp, got);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask : chk

   // Bounded wait on supply (sel 0) or module reset (sel 1)
   task automatic wt(input logic sel, input logic v);
      int i;
      for (i = 0; i < 300; i++)
      begin
         @(negedge sys_clk);
         if ((sel ? module_reset_n : supply_on_n) === v)
            return;
      end
      chk("wait bound", 16'h0, 16'h1);
      stop_test();
   endtask : wt

   task automatic do_reset(input mps_policy_t pol);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      ctrl.policy <= pol;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
   endtask : do_reset

   task automatic push();
      @(posedge sys_clk);
      press <= 1'b1;
      @(posedge sys_clk);
      press <= 1'b0;
   endtask : push

   task automatic t_always_on();
      do_reset(MPS_POL_ALWAYS_ON);
      wt(0, 1'b0);
      chk("held in reset", 16'h0, 16'(module_reset_n));
      wt(1, 1'b1);
      chk("powered", 16'h1, 16'(stat.powered));
      chk("in reset flag", 16'h0, 16'(stat.in_reset));
      pg_kill <= 1'b1;
      wt(1, 1'b0);
      chk("supply kept", 16'h0, 16'(supply_on_n));
      chk("in reset set", 16'h1, 16'(stat.in_reset));
      pg_kill <= 1'b0;
      wt(1, 1'b1);
      $display("test always_on done");
   endtask : t_always_on

   task automatic t_fan();
      int hi;
      for (int d = 0; d < 2; d++)
      begin
         @(posedge sys_clk);
         ctrl.fan_duty <= d ? 8'hff : 8'h40;
         repeat (300) @(posedge sys_clk);
         hi = 0;
         repeat (256) @(negedge sys_clk) hi += fan_drive_out;
         chk("pwm high", d ? 16'd256 : 16'd64, 16'(hi));
      end
      tach_on <= 1'b1;
      repeat (250) @(negedge sys_clk);
      // Window phase against the tach is free, so allow one revolution
      chk("revs", 16'h1, 16'(stat.fan_revs >= 5 && stat.fan_revs <= 7));
      tach_on <= 1'b0;
      $display("test fan done");
   endtask : t_fan

   task automatic t_watchdog();
      int irqs;
      int evs;
      logic [1:0] stg;
      irqs = 0;
      evs = 0;
      stg = 2'h0;
      @(posedge sys_clk);
      ctrl.wd_stage1 <= 32'd20;
      ctrl.wd_stage2 <= 32'd40;
      ctrl.wd_enable <= 1'b1;
      for (int i = 0; i < 60; i++)
      begin
         @(posedge sys_clk);
         ctrl.wd_kick <= (i % 10 == 0);
         @(negedge sys_clk);
         irqs += wd_irq;
      end
      chk("kicked irq", 16'h0, 16'(irqs));
      for (int i = 0; i < 300 && supply_on_n !== 1'b1; i++)
      begin
         @(negedge sys_clk);
         irqs += wd_irq;
         evs += stat.wd_event;
         if (wd_irq === 1'b1)
            stg = stat.wd_stage;
      end
      chk("irq pulses", 16'h1, 16'(irqs));
      chk("irq stage", 16'h1, 16'(stg));
      chk("wd events", 16'h2, 16'(evs));
      chk("final stage", 16'h2, 16'(stat.wd_stage));
      chk("wd off", 16'h1, 16'(supply_on_n));
      @(posedge sys_clk);
      ctrl.wd_enable <= 1'b0;
      $display("test watchdog done");
   endtask : t_watchdog

   task automatic t_button();
      do_reset(MPS_POL_REMAIN_OFF);
      repeat (20) @(negedge sys_clk);
      chk("stay off", 16'h1, 16'(supply_on_n));
      push();
      wt(0, 1'b0);
      wt(1, 1'b1);
      push();
      repeat (10) @(negedge sys_clk);
      chk("refused off", 16'h0, 16'(supply_on_n));
      @(posedge sys_clk);
      ctrl.btn_toggles <= 1'b1;
      push();
      wt(0, 1'b1);
      repeat (5) @(negedge sys_clk);
      chk("reset after off", 16'h0, 16'(module_reset_n));
      @(posedge sys_clk);
      ctrl.btn_toggles <= 1'b0;
      do_reset(MPS_POL_LAST_STATE);
      repeat (20) @(negedge sys_clk);
      chk("last state", 16'(!MPS_RST_LAST_ON), 16'(supply_on_n));
      $display("test button done");
   endtask : t_button

   initial
   begin
      rst_n = 1'b0;
      press = 1'b0;
      pg_kill = 1'b0;
      tach_on = 1'b0;
      ctrl = '0;
      t_always_on();
      t_fan();
      t_watchdog();
      t_button();
      stop_test();
   end
endmodule : mps_seq_bench
`default_nettype wire
